// ===== hdl/lbc_pkg.sv
// shared constants for the bipolar line code error detector
package lbc_pkg;

  // ****************************************************************
  // register map (byte addresses on the plain register port)
  // ****************************************************************
  localparam logic [7:0] LBC_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] LBC_STAT_ADDR   = 8'h04;
  localparam logic [7:0] LBC_CLR_ADDR    = 8'h08;
  localparam logic [7:0] LBC_IEN_ADDR    = 8'h0C;
  localparam logic [7:0] LBC_ERRCNT_ADDR = 8'h10;

  // control fields
  localparam int LBC_CTRL_RATE_BIT  = 0; // 1 = base rate, 0 = wide rate
  localparam int LBC_CTRL_CODE_BIT  = 1; // 1 = hdb3 errors to processor, 0 = ami
  localparam int LBC_CTRL_STEST_BIT = 2; // 1 = self-test source feeds the checker
  localparam logic [2:0] LBC_CTRL_RESET = 3'h3;

  // status / clear / enable fields
  localparam int LBC_EV_AMI   = 0;
  localparam int LBC_EV_HDB   = 1;
  localparam int LBC_EV_ALARM = 2;
  localparam int LBC_EV_W     = 3;

  // ****************************************************************
  // code and timing constants
  // ****************************************************************
  localparam logic [1:0] LBC_HDB_ZMAX  = 2'h3; // longest legal zero run
  localparam logic [1:0] LBC_HDB_VMIN  = 2'h2; // zeros ahead of a violation mark
  localparam int LBC_CLK_KHZ = 50000;          // system clock rate
  localparam int LBC_ST_KBPS = 2048;           // self-test bit rate
  localparam logic [15:0] LBC_ACC_STEP = 16'(LBC_ST_KBPS);
  localparam logic [15:0] LBC_ACC_MOD  = 16'(LBC_CLK_KHZ);

  // self-test generator states, gray coded
  typedef enum logic [1:0] {
    LBC_GEN_POS  = 2'b00,
    LBC_GEN_NEG  = 2'b01
  } lbc_gen_t;

endpackage

// ===== hdl/lbc_selftest.sv
// self-test source: bipolar 2048 kbit/s stream with injected errors
`timescale 1ns/1ns
`default_nettype none
module lbc_selftest
  import lbc_pkg::*;
(
  input  wire logic clk,      // system clock
  input  wire logic rstn,     // async reset, active low
  input  wire logic inject,   // one-cycle injection request
  output logic      bit_en,   // one-cycle pulse per generated bit
  output logic      pos_out,  // positive mark, full bit wide
  output logic      neg_out   // negative mark, full bit wide
);

  logic [15:0] acc_reg;
  logic [16:0] acc_sum;
  logic        pend_reg;
  lbc_gen_t    tog_reg;

  // ****************************************************************
  // bit rate divider
  // ****************************************************************
  // fractional accumulator keeps the long-term rate exact
  assign acc_sum = {1'b0, acc_reg} + {1'b0, LBC_ACC_STEP};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= 16'h0000;
      bit_en  <= 1'b0;
    end else if (acc_sum >= {1'b0, LBC_ACC_MOD}) begin
      acc_reg <= 16'(acc_sum - {1'b0, LBC_ACC_MOD});
      bit_en  <= 1'b1;
    end else begin
      acc_reg <= acc_sum[15:0];
      bit_en  <= 1'b0;
    end
  end

  // ****************************************************************
  // mark generator
  // ****************************************************************
  // injection waits for a positive mark so the extra one always repeats it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tog_reg  <= LBC_GEN_POS;
      pend_reg <= 1'b0;
      pos_out  <= 1'b0;
      neg_out  <= 1'b0;
    end else begin
      if (bit_en) begin
        case (tog_reg)
          LBC_GEN_POS: begin
            pos_out <= 1'b1;
            neg_out <= 1'b0;
            tog_reg <= LBC_GEN_NEG;
          end
          LBC_GEN_NEG: begin
            pos_out <= pend_reg; // toggle held while an injection is pending
            neg_out <= ~pend_reg;
            tog_reg <= pend_reg ? LBC_GEN_NEG : LBC_GEN_POS;
          end
          default: tog_reg <= LBC_GEN_POS;
        endcase
      end
      // a new request wins over the clear of the old one
      if (inject) begin
        pend_reg <= 1'b1;
      end else if (bit_en && tog_reg == LBC_GEN_NEG) begin
        pend_reg <= 1'b0;
      end
    end
  end

  a_inject_pos: assert property (@(posedge clk) disable iff (!rstn)
    bit_en && pend_reg && tog_reg == LBC_GEN_NEG |=> pos_out && $past(pos_out))
    else $error("injected mark is not a repeated positive mark");

endmodule
`default_nettype wire

// ===== hdl/lbc_code_check.sv
// ami and hdb3 code violation checker with pulse stretching
`timescale 1ns/1ns
`default_nettype none
module lbc_code_check
  import lbc_pkg::*;
(
  input  wire logic clk,      // system clock
  input  wire logic rstn,     // async reset, active low
  input  wire logic smp_en,   // one pulse per bit, falling line clock or self-test bit_en
  input  wire logic pos_in,   // positive pulse stream
  input  wire logic neg_in,   // negative pulse stream
  output logic      pos_str,  // positive data stretched to a bit
  output logic      neg_str,  // negative data stretched to a bit
  output logic      ami_err,  // ami error, one bit period wide
  output logic      hdb_err   // hdb3 error, one bit period wide
);

  logic       last_pol_reg, have_mark_reg, last_vpol_reg, have_viol_reg;
  logic [1:0] zrun_reg;
  logic       mark_w, pol_w, same_w, viol_w, zlong_w, vbad_w;

  // ****************************************************************
  // sampling and classification
  // ****************************************************************
  // both inputs high at once is not a mark; it cannot be told apart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_str <= 1'b0;
      neg_str <= 1'b0;
    end else if (smp_en) begin
      pos_str <= pos_in;
      neg_str <= neg_in;
    end
  end

  assign mark_w  = pos_str ^ neg_str;
  assign pol_w   = neg_str;
  assign same_w  = mark_w && have_mark_reg && (pol_w == last_pol_reg);
  assign viol_w  = same_w && (zrun_reg >= LBC_HDB_VMIN);
  assign vbad_w  = viol_w && have_viol_reg && (pol_w == last_vpol_reg);
  assign zlong_w = !mark_w && (zrun_reg == LBC_HDB_ZMAX);

  // ****************************************************************
  // history
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_pol_reg  <= 1'b0;
      have_mark_reg <= 1'b0;
      last_vpol_reg <= 1'b0;
      have_viol_reg <= 1'b0;
      zrun_reg      <= 2'h0;
    end else if (smp_en) begin
      if (mark_w) begin
        last_pol_reg  <= pol_w;
        have_mark_reg <= 1'b1;
        zrun_reg      <= 2'h0;
      end else if (zrun_reg != LBC_HDB_ZMAX) begin
        zrun_reg <= zrun_reg + 2'h1;
      end
      if (viol_w) begin
        last_vpol_reg <= pol_w;
        have_viol_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // retimed error outputs, held for exactly one bit period
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ami_err <= 1'b0;
      hdb_err <= 1'b0;
    end else if (smp_en) begin
      ami_err <= same_w;
      hdb_err <= (same_w && !viol_w) || vbad_w || zlong_w;
    end
  end

  a_ami_repeat: assert property (@(posedge clk) disable iff (!rstn)
    smp_en && mark_w && have_mark_reg && pol_w == last_pol_reg |=> ami_err)
    else $error("repeated mark polarity not flagged as ami error");

  a_hdb_normal: assert property (@(posedge clk) disable iff (!rstn)
    smp_en && same_w && zrun_reg < LBC_HDB_VMIN |=> hdb_err)
    else $error("repeated normal mark not flagged as hdb3 error");

  a_err_width: assert property (@(posedge clk) disable iff (!rstn)
    !smp_en |=> $stable(ami_err) && $stable(hdb_err))
    else $error("error output changed between bit samples");

endmodule
`default_nettype wire

// ===== hdl/lbc_top.sv
// bipolar line code error detector: top level with rate select and registers
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module lbc_top
  import lbc_pkg::*;
(
  input  wire logic        clk,                          // system clock, 50 MHz
  input  wire logic        rstn,                         // async reset, active low
  input  wire logic        pos_pulse_in,                 // separated positive pulses
  input  wire logic        neg_pulse_in,                 // separated negative pulses
  input  wire logic        rclk_base_in,                 // recovered base-rate clock
  input  wire logic        rclk_wide_in,                 // recovered wide-rate clock
  input  wire logic        density_bad_in,               // discriminator: bad density
  input  wire logic        level_loss_in,                // agc: input level lost
  input  wire logic        error_inject_input,           // injection pulse, level
  input  wire logic [7:0]  reg_addr,                     // register byte address
  input  wire logic [31:0] reg_wdata,                    // register write data
  input  wire logic        reg_wr,                       // write strobe
  input  wire logic        reg_rd,                       // read strobe
  output logic      [31:0] reg_rdata,                    // read data, cycle after strobe
  output logic             irq,                          // level interrupt
  output logic             stretched_pos,                // to frame alignment
  output logic             stretched_neg,                // to frame alignment
  output logic             align_clk_out,                // gated base clock to alignment
  output logic             recovered_clock_to_processor, // active recovered clock
  output logic             error_pulse_to_processor,     // retimed error pulse
  output logic             ami_err_out,                  // ami error detection
  output logic             hdb_err_out,                  // hdb3 error detection
  output logic             signal_alarm_flag,            // density or level alarm
  output logic             selftest_pos_out,             // self-test positive marks
  output logic             selftest_neg_out              // self-test negative marks
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [2:0]           ctrl_reg;
  logic [LBC_EV_W-1:0]  stat_reg;
  logic [LBC_EV_W-1:0]  ien_reg;
  logic [LBC_EV_W-1:0]  ev_w;
  logic [LBC_EV_W-1:0]  clr_w;
  logic [15:0]          errcnt_reg;
  logic                 wide_rate_code_mode;
  logic                 base_rate_code_mode;
  logic                 hdb_sel;
  logic                 stest_en;
  logic                 sel_clk_w;
  logic                 sel_clk_prev_reg;
  logic                 line_fall_w;
  logic                 smp_en_w;
  logic                 chk_pos_w;
  logic                 chk_neg_w;
  logic                 inj_prev_reg;
  logic                 inj_w;
  logic                 gen_bit_en;
  logic                 ami_w;
  logic                 hdb_w;
  logic                 ami_prev_reg;
  logic                 hdb_prev_reg;
  logic                 alarm_prev_reg;
  logic                 err_sel_w;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // rate select low means the wide rate, so reset leaves the base rate on
  assign base_rate_code_mode = ctrl_reg[LBC_CTRL_RATE_BIT];
  assign wide_rate_code_mode = ~ctrl_reg[LBC_CTRL_RATE_BIT];
  assign hdb_sel             = ctrl_reg[LBC_CTRL_CODE_BIT];
  assign stest_en            = ctrl_reg[LBC_CTRL_STEST_BIT];

  // ****************************************************************
  // recovered clock selection and falling edge detect
  // ****************************************************************
  // the line clocks are slow against clk, so a plain edge detect suffices
  assign sel_clk_w   = base_rate_code_mode ? rclk_base_in : rclk_wide_in;
  assign line_fall_w = sel_clk_prev_reg && !sel_clk_w;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_clk_prev_reg <= 1'b0;
    end else begin
      sel_clk_prev_reg <= sel_clk_w;
    end
  end

  // self-test replaces the line and its clock as the checker's source
  assign smp_en_w  = stest_en ? gen_bit_en : line_fall_w;
  assign chk_pos_w = stest_en ? selftest_pos_out : pos_pulse_in;
  assign chk_neg_w = stest_en ? selftest_neg_out : neg_pulse_in;

  // ****************************************************************
  // clocks and alarm towards alignment logic and processor
  // ****************************************************************
  // registered copies keep these outputs free of mux glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      align_clk_out                <= 1'b0;
      recovered_clock_to_processor <= 1'b0;
      signal_alarm_flag            <= 1'b0;
    end else begin
      align_clk_out                <= rclk_base_in && base_rate_code_mode;
      recovered_clock_to_processor <= sel_clk_w;
      signal_alarm_flag            <= density_bad_in || level_loss_in;
    end
  end

  // ****************************************************************
  // self-test injection edge and generator
  // ****************************************************************
  // the processor paces injections; only the rising edge counts
  assign inj_w = error_inject_input && !inj_prev_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inj_prev_reg <= 1'b0;
    end else begin
      inj_prev_reg <= error_inject_input;
    end
  end

  lbc_selftest u_selftest (
    .clk     (clk),
    .rstn    (rstn),
    .inject  (inj_w),
    .bit_en  (gen_bit_en),
    .pos_out (selftest_pos_out),
    .neg_out (selftest_neg_out)
  );

  // ****************************************************************
  // code checker
  // ****************************************************************
  lbc_code_check u_check (
    .clk     (clk),
    .rstn    (rstn),
    .smp_en  (smp_en_w),
    .pos_in  (chk_pos_w),
    .neg_in  (chk_neg_w),
    .pos_str (stretched_pos),
    .neg_str (stretched_neg),
    .ami_err (ami_w),
    .hdb_err (hdb_w)
  );

  assign ami_err_out = ami_w;
  assign hdb_err_out = hdb_w;

  // ****************************************************************
  // error pulse to processor
  // ****************************************************************
  // the checker outputs already come from a register stage; one more
  // stage isolates the processor line from the code select mux
  assign err_sel_w = hdb_sel ? hdb_w : ami_w;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      error_pulse_to_processor <= 1'b0;
    end else begin
      error_pulse_to_processor <= err_sel_w;
    end
  end

  // ****************************************************************
  // events, sticky status and interrupt
  // ****************************************************************
  // a level held over many bits is one event per new error bit period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ami_prev_reg   <= 1'b0;
      hdb_prev_reg   <= 1'b0;
      alarm_prev_reg <= 1'b0;
    end else begin
      ami_prev_reg   <= ami_w && !smp_en_w;
      hdb_prev_reg   <= hdb_w && !smp_en_w;
      alarm_prev_reg <= signal_alarm_flag;
    end
  end

  assign ev_w[LBC_EV_AMI]   = ami_w && !ami_prev_reg;
  assign ev_w[LBC_EV_HDB]   = hdb_w && !hdb_prev_reg;
  assign ev_w[LBC_EV_ALARM] = signal_alarm_flag && !alarm_prev_reg;
  assign clr_w = (reg_wr && reg_addr == LBC_CLR_ADDR) ? reg_wdata[LBC_EV_W-1:0] : '0;

  // set beats clear when both land in the same cycle
  generate
    for (genvar i = 0; i < LBC_EV_W; i++) begin : g_stat
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stat_reg[i] <= 1'b0;
        end else if (ev_w[i]) begin
          stat_reg[i] <= 1'b1;
        end else if (clr_w[i]) begin
          stat_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(stat_reg & ien_reg);

  // ****************************************************************
  // error counter
  // ****************************************************************
  // saturates so software never sees a wrapped, falsely low count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      errcnt_reg <= 16'h0000;
    end else if (reg_wr && reg_addr == LBC_ERRCNT_ADDR) begin
      errcnt_reg <= 16'h0000;
    end else if (smp_en_w && err_sel_w && errcnt_reg != 16'hFFFF) begin
      errcnt_reg <= errcnt_reg + 16'h0001;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= LBC_CTRL_RESET;
      ien_reg  <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        LBC_CTRL_ADDR: ctrl_reg <= reg_wdata[2:0];
        LBC_IEN_ADDR:  ien_reg  <= reg_wdata[LBC_EV_W-1:0];
        default:       ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ****************************************************************
  // register reads, data in the cycle after the strobe only
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        LBC_CTRL_ADDR:   reg_rdata <= {29'h00000000, ctrl_reg};
        LBC_STAT_ADDR:   reg_rdata <= {29'h00000000, stat_reg};
        LBC_IEN_ADDR:    reg_rdata <= {29'h00000000, ien_reg};
        LBC_ERRCNT_ADDR: reg_rdata <= {16'h0000, errcnt_reg};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sample_edge: assert property (@(posedge clk) disable iff (!rstn)
    !stest_en && smp_en_w |-> $past(sel_clk_w) && !sel_clk_w)
    else $error("line sample not on a falling recovered clock edge");

  a_wide_blocks: assert property (@(posedge clk) disable iff (!rstn)
    wide_rate_code_mode ##1 wide_rate_code_mode |-> !align_clk_out)
    else $error("base clock reached alignment in wide-rate mode");

  a_clk_forward: assert property (@(posedge clk) disable iff (!rstn)
    base_rate_code_mode ##1 base_rate_code_mode |->
      recovered_clock_to_processor == $past(rclk_base_in))
    else $error("forwarded clock does not follow the active rate");

  a_alarm_flag: assert property (@(posedge clk) disable iff (!rstn)
    level_loss_in || density_bad_in |=> signal_alarm_flag)
    else $error("alarm flag missing after density or level fault");

  a_err_retime: assert property (@(posedge clk) disable iff (!rstn)
    hdb_sel && hdb_w ##1 hdb_sel |-> error_pulse_to_processor)
    else $error("hdb3 error did not reach the processor one cycle later");

  a_stretch_out: assert property (@(posedge clk) disable iff (!rstn)
    smp_en_w ##1 !smp_en_w |=> $stable(stretched_pos) && $stable(stretched_neg))
    else $error("stretched data changed inside a bit period");

  a_status_sticky: assert property (@(posedge clk) disable iff (!rstn)
    ev_w[LBC_EV_HDB] |=> stat_reg[LBC_EV_HDB])
    else $error("hdb3 status bit did not stick after an error");

  a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    irq == |(stat_reg & ien_reg))
    else $error("interrupt does not match enabled status");

  a_ami_retime: assert property (@(posedge clk) disable iff (!rstn)
    !hdb_sel && ami_w ##1 !hdb_sel |-> error_pulse_to_processor)
    else $error("ami error did not reach the processor one cycle later");

  a_align_follow: assert property (@(posedge clk) disable iff (!rstn)
    base_rate_code_mode ##1 base_rate_code_mode |-> align_clk_out == $past(rclk_base_in))
    else $error("alignment clock does not follow the base clock");

  a_wide_forward: assert property (@(posedge clk) disable iff (!rstn)
    wide_rate_code_mode ##1 wide_rate_code_mode |->
      recovered_clock_to_processor == $past(rclk_wide_in))
    else $error("forwarded clock does not follow the wide-rate clock");

  a_alarm_release: assert property (@(posedge clk) disable iff (!rstn)
    !level_loss_in && !density_bad_in |=> !signal_alarm_flag)
    else $error("alarm flag stayed high without a fault");

  a_stest_source: assert property (@(posedge clk) disable iff (!rstn)
    stest_en && gen_bit_en |=> stretched_pos == $past(selftest_pos_out))
    else $error("self-test mark not taken by the checker");

  // a count step is one per sampled error, so a held error level is not recounted
  a_errcnt_step: assert property (@(posedge clk) disable iff (!rstn)
    smp_en_w && err_sel_w && errcnt_reg != 16'hFFFF &&
      !(reg_wr && reg_addr == LBC_ERRCNT_ADDR) |=>
      errcnt_reg == $past(errcnt_reg) + 16'h0001)
    else $error("error count did not step by one");

  a_pulse_hold: assert property (@(posedge clk) disable iff (!rstn)
    !smp_en_w && !reg_wr ##1 !smp_en_w && !reg_wr |=> $stable(error_pulse_to_processor))
    else $error("error pulse changed inside a bit period");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data present without a read strobe");

  a_status_clear: assert property (@(posedge clk) disable iff (!rstn)
    clr_w[LBC_EV_AMI] && !ev_w[LBC_EV_AMI] |=> !stat_reg[LBC_EV_AMI])
    else $error("ami status bit not cleared by a clear write");

  a_ami_status: assert property (@(posedge clk) disable iff (!rstn)
    ev_w[LBC_EV_AMI] |=> stat_reg[LBC_EV_AMI])
    else $error("ami status bit not set after an error");

endmodule
`default_nettype wire

// ===== bench/lbc_line_model.sv
// line receiver model: recovered clock and bipolar marks
`timescale 1ns/1ns
`default_nettype none
module lbc_line_model (
  input  wire logic clk,     // system clock
  input  wire logic rstn,    // async reset, active low
  input  wire logic err_req, // repeat last polarity once
  output logic      rclk,    // recovered clock, 24 clk a bit
  output logic      pos,     // positive marks
  output logic      neg      // negative marks
);
  logic [4:0] div_reg;
  logic       pol_reg;
  logic       err_reg;
  // marks move on the rising line clock, so the falling edge sees settled data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 5'h00;
      rclk    <= 1'b0;
      pos     <= 1'b0;
      neg     <= 1'b0;
      pol_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == 5'h17) ? 5'h00 : div_reg + 5'h01;
      if (div_reg == 5'h0B) rclk <= 1'b0;
      if (div_reg == 5'h17) begin
        rclk    <= 1'b1;
        pol_reg <= err_reg ? pol_reg : !pol_reg;
        pos     <= err_reg ? pol_reg : !pol_reg;
        neg     <= err_reg ? !pol_reg : pol_reg;
        err_reg <= err_req;
      end else if (err_req) err_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the line code error detector
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lbc_pkg::*;
  logic clk = 0, rstn = 0, den = 0, los = 0, inj = 0, lerr = 0, rwr = 0, rrd = 0, rd_d = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic rclk, lpos, lneg, irq, ami, hdb, epp, aclk, alarm;
  logic spos, sneg, rcp, stpos, stneg, rclk_d = 0;
  int fails = 0, cmp_count = 0, n_ami = 0, n_hdb = 0, n_epp = 0, seed = 31;
  logic [31:0] exp_q[$];
  lbc_line_model lm_u (.clk(clk), .rstn(rstn), .err_req(lerr), .rclk(rclk), .pos(lpos), .neg(lneg));
  lbc_top dut_u (.clk(clk), .rstn(rstn), .pos_pulse_in(lpos), .neg_pulse_in(lneg),
    .rclk_base_in(rclk), .rclk_wide_in(rclk), .density_bad_in(den), .level_loss_in(los),
    .error_inject_input(inj), .reg_addr(addr), .reg_wdata(wdat), .reg_wr(rwr), .reg_rd(rrd),
    .reg_rdata(rdat), .irq(irq), .stretched_pos(spos), .stretched_neg(sneg),
    .align_clk_out(aclk), .recovered_clock_to_processor(rcp), .error_pulse_to_processor(epp),
    .ami_err_out(ami), .hdb_err_out(hdb), .signal_alarm_flag(alarm),
    .selftest_pos_out(stpos), .selftest_neg_out(stneg));
  always #10 clk = ~clk;
  // one pulse per error, so rising edges count errors
  always @(posedge ami) n_ami++;
  always @(posedge hdb) n_hdb++;
  always @(posedge epp) n_epp++;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a gap cycle after each strobe keeps every strobe one cycle long
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    rwr <= 1'b1;
    @(posedge clk) rwr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    rrd <= 1'b1;
    @(posedge clk) rrd <= 1'b0;
    @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rrd;
    if (rd_d) check(rdat, exp_q.pop_front());
  end
  // both rate inputs carry the model clock, so the forward is its one-cycle copy
  always @(posedge clk) begin
    rclk_d <= rclk;
    if (rstn) check(32'(rcp), 32'(rclk_d));
  end
  task automatic errs(input int n);
    repeat (n) begin
      repeat (($random(seed) & 63) + 50) @(posedge clk);
      lerr <= 1'b1;
      @(posedge clk) lerr <= 1'b0;
    end
    repeat (100) @(posedge clk);
  endtask
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(LBC_CTRL_ADDR, 32'(LBC_CTRL_RESET));
    rd(8'h3C, 32'h0);
    wr(LBC_IEN_ADDR, 32'h4);
    den <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(alarm), 32'h1);
    check(32'(irq), 32'h1);
    den <= 1'b0;
    los <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(alarm), 32'h1);
    rd(LBC_STAT_ADDR, 32'h4);
    wr(LBC_CLR_ADDR, 32'h4);
    los <= 1'b0;
    check(32'(irq), 32'h0);
    repeat (200) @(posedge clk);
    wr(LBC_ERRCNT_ADDR, 32'h0);
    n_ami = 0;
    n_hdb = 0;
    n_epp = 0;
    errs(6);
    check(n_ami, 6);
    check(n_hdb, 6);
    check(n_epp, 6);
    check(32'(spos ^ sneg), 32'h1);
    rd(LBC_ERRCNT_ADDR, 32'h6);
    wr(LBC_CTRL_ADDR, 32'h2);
    errs(3);
    check(n_ami, 9);
    check(32'(aclk), 32'h0);
    wr(LBC_CTRL_ADDR, 32'h7);
    repeat (200) @(posedge clk);
    wr(LBC_ERRCNT_ADDR, 32'h0);
    inj <= 1'b1;
    @(posedge clk) inj <= 1'b0;
    repeat (300) @(posedge clk);
    rd(LBC_ERRCNT_ADDR, 32'h1);
    check(32'(stpos ^ stneg), 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
